// file: design/udt_top.sv
// Top: USB descriptor table addressing with register port
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module udt_top (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    // Register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    // Transfer engine side
    input  wire logic        lookup_i,
    input  wire logic [3:0]  endpoint_i,
    input  wire logic        dir_tx_i,
    input  wire logic        odd_i,
    input  wire logic        rx_done_i,
    input  wire logic [3:0]  rx_src_ep_i,
    output logic             busy_o,
    output logic             done_o,
    output logic      [15:0] entry_addr_o,
    output logic      [5:0]  entry_index_o,
    output logic      [15:0] desc_stat_o,
    output logic      [15:0] desc_buf_addr_o,
    output logic      [3:0]  dest_ep_o,
    output logic      [7:0]  ep_ctrl_o,
    // Data RAM read port
    output logic             ram_req_o,
    output logic      [15:0] ram_addr_o,
    input  wire logic        ram_ack_i,
    input  wire logic [15:0] ram_rdata_i
);
    udt_ram_if ram_bus ();

    logic [7:0]  base_ptr_r;
    logic [1:0]  ppb_r;
    logic        host_mode_r;
    logic [7:0]  token_r;
    logic [7:0]  status_r;
    logic [7:0]  status_nxt;
    logic [7:0]  ep0_ctrl_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [5:0]  index_w;
    logic [15:0] table_base;
    logic [15:0] entry_addr;
    logic [15:0] entry_addr_r;
    logic [5:0]  index_r;
    logic [3:0]  stat_ep;
    logic        wr_base;
    logic        wr_cfg;
    logic        wr_mode;
    logic        wr_tok;
    logic        wr_ep0;
    logic        start;
    logic        fetch_busy;
    logic        fetch_done;
    logic [15:0] fetch_stat;
    logic [15:0] fetch_adr;

    // Register write decode
    assign wr_base = reg_wr_i && (reg_addr_i == udt_pkg::OFS_BASE_PTR);
    assign wr_cfg  = reg_wr_i && (reg_addr_i == udt_pkg::OFS_CONFIG);
    assign wr_mode = reg_wr_i && (reg_addr_i == udt_pkg::OFS_MODE);
    assign wr_tok  = reg_wr_i && (reg_addr_i == udt_pkg::OFS_TOKEN);
    assign wr_ep0  = reg_wr_i && (reg_addr_i == udt_pkg::OFS_EP0_CTRL);

    // Base byte with bit 0 forced low keeps 512-byte alignment
    assign table_base = {base_ptr_r[7:1], 9'h000};
    // Index times four stays within 256 bytes of the base
    assign entry_addr = 16'(table_base
                      + {8'h00, index_w, 2'b00});

    udt_index_map u_map (
        .endpoint_i  (endpoint_i),
        .dir_tx_i    (dir_tx_i),
        .odd_i       (odd_i),
        .ppb_i       (ppb_r),
        .host_mode_i (host_mode_r),
        .index_o     (index_w)
    );

    assign start = lookup_i && !fetch_busy;

    udt_fetch u_fetch (
        .clock_i      (clock_i),
        .reset_i      (reset_i),
        .ce_i         (ce_i),
        .start_i      (start),
        .entry_addr_i (entry_addr),
        .ram          (ram_bus.master),
        .busy_o       (fetch_busy),
        .done_o       (fetch_done),
        .stat_o       (fetch_stat),
        .adr_o        (fetch_adr)
    );

    assign ram_req_o     = ram_bus.req;
    assign ram_addr_o    = ram_bus.addr;
    assign ram_bus.ack   = ram_ack_i;
    assign ram_bus.rdata = ram_rdata_i;

    assign busy_o          = fetch_busy;
    assign done_o          = fetch_done;
    assign desc_stat_o     = fetch_stat;
    assign desc_buf_addr_o = fetch_adr;
    assign entry_addr_o    = entry_addr_r;
    assign entry_index_o   = index_r;
    // Host and device mode both send to the endpoint in the token register
    assign dest_ep_o  = token_r[udt_pkg::TOK_EP_LSB +: 4];
    assign ep_ctrl_o  = ep0_ctrl_r;

    // Host reports remote source endpoint, device its own
    assign stat_ep = host_mode_r ? rx_src_ep_i : endpoint_i;

    always_comb begin
        status_nxt = status_r;
        if (rx_done_i) begin
            status_nxt[udt_pkg::STAT_EP_LSB +: 4] = stat_ep;
            status_nxt[udt_pkg::STAT_DIR] = dir_tx_i;
            status_nxt[udt_pkg::STAT_ODD] = odd_i;
        end
    end

    always_comb begin
        rdata_nxt = 16'h0000;
        unique case (reg_addr_i)
            udt_pkg::OFS_BASE_PTR: rdata_nxt = {8'h00, base_ptr_r};
            udt_pkg::OFS_CONFIG:   rdata_nxt = {14'h0000, ppb_r};
            udt_pkg::OFS_MODE:     rdata_nxt = {15'h0000, host_mode_r};
            udt_pkg::OFS_TOKEN:    rdata_nxt = {8'h00, token_r};
            udt_pkg::OFS_STATUS:   rdata_nxt = {8'h00, status_r};
            udt_pkg::OFS_EP0_CTRL: rdata_nxt = {8'h00, ep0_ctrl_r};
            udt_pkg::OFS_ENTRY:    rdata_nxt = entry_addr_r;
            udt_pkg::OFS_BUF_ADR:  rdata_nxt = fetch_adr;
            default:               rdata_nxt = 16'h0000;
        endcase
    end

    assign reg_rdata_o = rdata_r;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            base_ptr_r   <= udt_pkg::BASE_PTR_RST;
            ppb_r        <= udt_pkg::PPB_RST;
            host_mode_r  <= 1'b0;
            token_r      <= udt_pkg::TOKEN_RST;
            ep0_ctrl_r   <= udt_pkg::EP0_CTRL_RST;
            status_r     <= 8'h00;
            rdata_r      <= 16'h0000;
            entry_addr_r <= 16'h0000;
            index_r      <= 6'h00;
        end else if (ce_i) begin
            if (wr_base) base_ptr_r <= reg_wdata_i[7:0];
            if (wr_cfg)  ppb_r <= reg_wdata_i[1:0];
            if (wr_mode) host_mode_r <= reg_wdata_i[0];
            if (wr_tok)  token_r <= reg_wdata_i[7:0];
            if (wr_ep0)  ep0_ctrl_r <= reg_wdata_i[7:0];
            status_r <= status_nxt;
            rdata_r  <= reg_rd_i ? rdata_nxt : 16'h0000;
            if (start) begin
                entry_addr_r <= entry_addr;
                index_r      <= index_w;
            end
        end
    end
endmodule

// file: design/udt_pkg.sv
// Package: constants for the USB descriptor table addressing block
// Functional notes
// - Table sits in any free 512-byte aligned 512-byte RAM block.
// - Table base upper byte comes from the base pointer register.
// - Each entry is a 16-bit status word plus a 16-bit buffer address.
// - Up to 64 entries, indexed 0 to 63.
// - Buffer addresses are 16 bits, so only the first 64 Kbytes reach.
// - A full table of 64 entries occupies at most 256 bytes.
// - Index comes from endpoint, direction and two-bit ping-pong mode.
// - Host mode uses only endpoint 0 descriptors and endpoint 0 control.
// - Host mode reports received source endpoint in status bits 7 to 4.
// - Host mode sends to the endpoint written in the token register.
package udt_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int IDX_W  = 6;

    // Register offsets
    localparam logic [3:0] OFS_BASE_PTR = 4'h0;
    localparam logic [3:0] OFS_CONFIG   = 4'h1;
    localparam logic [3:0] OFS_MODE     = 4'h2;
    localparam logic [3:0] OFS_TOKEN    = 4'h3;
    localparam logic [3:0] OFS_STATUS   = 4'h4;
    localparam logic [3:0] OFS_EP0_CTRL = 4'h5;
    localparam logic [3:0] OFS_ENTRY    = 4'h6;
    localparam logic [3:0] OFS_BUF_ADR  = 4'h7;

    // Field positions
    localparam int STAT_EP_LSB = 4;
    localparam int STAT_DIR    = 3;
    localparam int STAT_ODD    = 2;
    localparam int TOK_EP_LSB  = 0;

    // Reset values
    localparam logic [7:0]  BASE_PTR_RST = 8'h00;
    localparam logic [1:0]  PPB_RST      = 2'h0;
    localparam logic [7:0]  EP0_CTRL_RST = 8'h00;
    localparam logic [7:0]  TOKEN_RST    = 8'h00;

    // Table geometry
    localparam int TABLE_BYTES = 512;
    localparam int ENTRY_BYTES = 4;
    localparam int MAX_ENTRIES = 64;
    localparam int ENTRY_SHIFT = 2;

    // Ping-pong modes
    typedef enum logic [1:0] {
        UDT_PP_NONE,
        UDT_PP_EP0_OUT,
        UDT_PP_ALL,
        UDT_PP_EP1_UP
    } udt_pp_t;

    typedef enum logic [1:0] {
        UDT_RD_IDLE,
        UDT_RD_STAT,
        UDT_RD_ADR
    } udt_fetch_t;
endpackage

// file: design/udt_ram_if.sv
// Interface: descriptor RAM read request and answer
`timescale 1ns/1ps
interface udt_ram_if;
    logic        req;
    logic [15:0] addr;
    logic        ack;
    logic [15:0] rdata;
    modport master (output req, output addr, input ack, input rdata);
    modport slave  (input req, input addr, output ack, output rdata);
endinterface

// file: design/udt_index_map.sv
// Descriptor index selection from endpoint, direction and ping-pong mode
`timescale 1ns/1ps
module udt_index_map (
    input  wire logic [3:0] endpoint_i,
    input  wire logic       dir_tx_i,
    input  wire logic       odd_i,
    input  wire logic [1:0] ppb_i,
    input  wire logic       host_mode_i,
    output logic      [5:0] index_o
);
    logic [3:0] ep;
    logic [5:0] idx_none;
    logic [5:0] idx_ep0;
    logic [5:0] idx_all;
    logic [5:0] idx_up;

    // Host traffic always goes through endpoint 0 entries
    assign ep = host_mode_i ? 4'h0 : endpoint_i;

    assign idx_none = {1'b0, ep, dir_tx_i};
    assign idx_all  = {ep, dir_tx_i, odd_i};
    // Only endpoint 0 receive is double buffered
    assign idx_ep0  = (ep == 4'h0) ?
                      (dir_tx_i ? 6'h02 : {5'h00, odd_i}) :
                      6'({1'b0, ep, dir_tx_i} + 6'h01);
    // Endpoints 1 and up double buffered, endpoint 0 single
    assign idx_up   = (ep == 4'h0) ? {5'h00, dir_tx_i} :
                      6'({ep, dir_tx_i, odd_i} - 6'h02);

    always_comb begin
        unique case (udt_pkg::udt_pp_t'(ppb_i))
            udt_pkg::UDT_PP_NONE:    index_o = idx_none;
            udt_pkg::UDT_PP_EP0_OUT: index_o = idx_ep0;
            udt_pkg::UDT_PP_ALL:     index_o = idx_all;
            udt_pkg::UDT_PP_EP1_UP:  index_o = idx_up;
        endcase
    end
endmodule

// file: design/udt_fetch.sv
// Fetcher: reads status and buffer address words of one descriptor
`timescale 1ns/1ps
module udt_fetch (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    input  wire logic        start_i,
    input  wire logic [15:0] entry_addr_i,
    udt_ram_if.master        ram,
    output logic             busy_o,
    output logic             done_o,
    output logic      [15:0] stat_o,
    output logic      [15:0] adr_o
);
    udt_pkg::udt_fetch_t state_r;
    udt_pkg::udt_fetch_t state_nxt;
    logic [15:0] base_r;
    logic [15:0] stat_r;
    logic [15:0] adr_r;
    logic        done_r;
    logic        take;

    assign take     = ram.req && ram.ack;
    assign ram.req  = (state_r != udt_pkg::UDT_RD_IDLE);
    // Status word first, buffer address word two bytes on
    assign ram.addr = (state_r == udt_pkg::UDT_RD_ADR) ?
                      16'(base_r + 16'h0002) : base_r;
    assign busy_o   = ram.req;
    assign done_o   = done_r;
    assign stat_o   = stat_r;
    assign adr_o    = adr_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            udt_pkg::UDT_RD_IDLE:
                if (start_i) state_nxt = udt_pkg::UDT_RD_STAT;
            udt_pkg::UDT_RD_STAT:
                if (take) state_nxt = udt_pkg::UDT_RD_ADR;
            udt_pkg::UDT_RD_ADR:
                if (take) state_nxt = udt_pkg::UDT_RD_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_r <= udt_pkg::UDT_RD_IDLE;
            base_r  <= 16'h0000;
            stat_r  <= 16'h0000;
            adr_r   <= 16'h0000;
            done_r  <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            done_r  <= take && (state_r == udt_pkg::UDT_RD_ADR);
            if (start_i && state_r == udt_pkg::UDT_RD_IDLE) begin
                base_r <= entry_addr_i;
            end
            if (take && state_r == udt_pkg::UDT_RD_STAT) begin
                stat_r <= ram.rdata;
            end
            if (take && state_r == udt_pkg::UDT_RD_ADR) begin
                adr_r <= ram.rdata;
            end
        end
    end
endmodule

// file: sim/udt_ram_model.sv
// Partner: data RAM answering descriptor word reads
`timescale 1ns/1ps
module udt_ram_model (
    input  wire logic        clock_i,
    input  wire logic        req_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        slow_i,
    output logic             ack_o,
    output logic      [15:0] rdata_o
);
    logic tog_r;
    always_ff @(posedge clock_i) tog_r <= req_i & ~tog_r;
    // Slow mode answers every other cycle
    assign ack_o = req_i & (~slow_i | tog_r);
    // Filled everywhere; inverse while not answering
    assign rdata_o = ack_o ? addr_i ^ 16'ha5c3 : ~addr_i;
endmodule

// file: sim/udt_top_sva.sv
// Checker: register port and descriptor fetch assertions
`timescale 1ns/1ps
module udt_top_sva (
    input wire logic        clock_i,
    input wire logic        reset_i,
    input wire logic        ce_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        lookup_i,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire logic [15:0] entry_addr_o,
    input wire logic [5:0]  entry_index_o,
    input wire logic [3:0]  dest_ep_o,
    input wire logic        ram_req_o,
    input wire logic [15:0] ram_addr_o,
    input wire logic        ram_ack_i
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    rdata_idle_a: assert property (ce_i && !reg_rd_i
        |=> reg_rdata_o == 16'h0) else $error("read data not idle");
    entry_geom_a: assert property (
        entry_addr_o[8:0] == {1'b0, entry_index_o, 2'b00})
        else $error("entry address off index");
    first_word_a: assert property ($rose(ram_req_o)
        |-> ram_addr_o == entry_addr_o) else $error("bad first word");
    second_word_a: assert property (
        ram_req_o && ram_ack_i && !ram_addr_o[1] && ce_i
        |=> ram_req_o && ram_addr_o == $past(ram_addr_o) + 16'h2)
        else $error("bad second word");
    done_after_a: assert property (
        ram_req_o && ram_ack_i && ram_addr_o[1] && ce_i
        |=> done_o && !ram_req_o) else $error("done late");
    take_req_a: assert property (lookup_i && !busy_o && ce_i
        |=> ram_req_o) else $error("lookup not taken");
    busy_req_a: assert property (busy_o == ram_req_o)
        else $error("busy differs from request");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done too long");
    dest_ep_a: assert property (ce_i && reg_wr_i
        && reg_addr_i == 4'h3
        |=> {12'h0, dest_ep_o} == ($past(reg_wdata_i) & 16'h000f))
        else $error("destination endpoint wrong");
    cover property (done_o);
    cover property (lookup_i && busy_o);
    cover property (reg_wr_i && reg_addr_i == 4'h2);
endmodule
bind udt_top udt_top_sva u_udt_top_sva (.*);

// file: sim/udt_top_tb_top.sv
// Testbench: scenarios for the descriptor table block
`timescale 1ns/1ps
module udt_top_tb_top;
    logic        clock_i, reset_i, ce_i, reg_wr_i, reg_rd_i;
    logic [3:0]  reg_addr_i, endpoint_i, rx_src_ep_i, dest_ep_o;
    logic [15:0] reg_wdata_i, reg_rdata_o, entry_addr_o;
    logic [15:0] desc_stat_o, desc_buf_addr_o, ram_addr_o;
    logic [15:0] ram_rdata_i;
    logic        lookup_i, dir_tx_i, odd_i, rx_done_i, busy_o, done_o;
    logic        ram_req_o, ram_ack_i, slow, host;
    logic [5:0]  entry_index_o;
    logic [7:0]  ep_ctrl_o, base;
    logic [1:0]  pp;
    int          miscompares, checks_done;
    udt_top u_udt_top (.*);
    udt_ram_model u_udt_ram_model (.clock_i(clock_i),
        .req_i(ram_req_o), .addr_i(ram_addr_o), .slow_i(slow),
        .ack_o(ram_ack_i), .rdata_o(ram_rdata_i));
    initial begin
        clock_i = 0;
        forever #25 clock_i = ~clock_i;
    end
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 chk("read data", e, reg_rdata_o & m);
    endtask
    function automatic logic [5:0] xi(input logic [3:0] e, input d, o);
        logic [3:0] p;
        p = host ? 4'h0 : e;
        case (pp)
            2'h0: xi = {1'b0, p, d};
            2'h1: xi = p == 0 ? (d ? 6'h2 : {5'h0, o})
                              : 6'({1'b0, p, d} + 6'h1);
            2'h2: xi = {p, d, o};
            default: xi = p == 0 ? {5'h0, d} : {p, d, o} - 6'h2;
        endcase
    endfunction
    task automatic finish(input logic [3:0] e, input d, o);
        logic [15:0] ea;
        int          n;
        ea = {base[7:1], 9'h0} + {8'h0, xi(e, d, o), 2'b00};
        n = 0;
        while (done_o !== 1'b1 && n < 40) begin
            @(posedge clock_i);
            #1 n++;
        end
        chk("done", 16'h1, {15'h0, done_o});
        chk("index", {10'h0, xi(e, d, o)}, {10'h0, entry_index_o});
        chk("entry", ea, entry_addr_o);
        chk("status", ea ^ 16'ha5c3, desc_stat_o);
        chk("buffer", (ea + 2) ^ 16'ha5c3, desc_buf_addr_o);
    endtask
    task automatic start(input logic [3:0] e, input d, o, hold);
        @(posedge clock_i);
        endpoint_i <= e;
        dir_tx_i <= d;
        odd_i <= o;
        lookup_i <= 1'b1;
        @(posedge clock_i);
        lookup_i <= hold;
        if (hold) endpoint_i <= ~e;
    endtask
    task automatic t_regs;
        for (int a = 0; a < 16; a++) rd(a[3:0], 16'h0, 16'hffff);
        wr(4'h9, 16'hffff);
        rd(4'h9, 16'h0, 16'hffff);
        wr(4'h6, 16'hffff);
        rd(4'h6, 16'h0, 16'hffff);
        wr(4'h0, 16'hffff);
        rd(4'h0, 16'h00ff, 16'hffff);
        // Write while the clock enable is low must not land
        ce_i <= 1'b0;
        wr(4'h0, 16'h0012);
        ce_i <= 1'b1;
        rd(4'h0, 16'h00ff, 16'hffff);
        $display("test regs done");
    endtask
    task automatic t_map;
        base = 8'h35;
        wr(4'h0, 16'h0035);
        for (int m = 0; m < 4; m++) begin
            // Mode 2 and endpoint 15 last, so the final entry is index 63
            pp = m[1:0] ^ 2'h1;
            wr(4'h1, {14'h0, pp});
            foreach (base[i]) if (i < 3) begin
                for (int k = 0; k < 4; k++) begin
                    start(i == 0 ? 4'hf : 4'(2 - i), k[1], k[0], 1'b0);
                    finish(i == 0 ? 4'hf : 4'(2 - i), k[1], k[0]);
                end
            end
        end
        rd(4'h6, {7'h1a, 9'h0} + 16'hfc, 16'hffff);
        $display("test map done");
    endtask
    task automatic t_host;
        pp = 2'h0;
        host = 1'b1;
        wr(4'h1, 16'h0);
        wr(4'h2, 16'h1);
        wr(4'h3, 16'h0037);
        wr(4'h5, 16'h005a);
        #1 chk("dest", 16'h7, {12'h0, dest_ep_o});
        chk("ctrl", 16'h5a, {8'h0, ep_ctrl_o});
        start(4'h9, 1'b1, 1'b0, 1'b0);
        finish(4'h9, 1'b1, 1'b0);
        chk("ep0 area", 16'h0, {10'h0, entry_addr_o[8:3]});
        for (int h = 1; h >= 0; h--) begin
            wr(4'h2, 16'(h));
            @(posedge clock_i);
            rx_src_ep_i <= 4'hc;
            rx_done_i <= 1'b1;
            @(posedge clock_i);
            rx_done_i <= 1'b0;
            rd(4'h4, h ? 16'h00c0 : 16'h0090, 16'h00f0);
        end
        host = 1'b0;
        $display("test host done");
    endtask
    task automatic t_slow;
        slow <= 1'b1;
        start(4'h3, 1'b0, 1'b1, 1'b1);
        finish(4'h3, 1'b0, 1'b1);
        @(posedge clock_i);
        lookup_i <= 1'b0;
        #1 finish(4'hc, 1'b0, 1'b1);
        rd(4'h7, ({7'h1a, 9'h0} + 16'h62) ^ 16'ha5c3, 16'hffff);
        slow <= 1'b0;
        $display("test slow done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {reg_wr_i, reg_rd_i, lookup_i, dir_tx_i, odd_i, rx_done_i} = 0;
        {reg_addr_i, endpoint_i, rx_src_ep_i, reg_wdata_i} = 0;
        {slow, host, pp, base} = 0;
        ce_i = 1'b1;
        reset_i = 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        t_regs;
        t_map;
        t_host;
        t_slow;
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        tally_and_finish;
    end
endmodule
